// ### arc_pkg.sv
package arc_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned MS_CYCLES_DFLT = CLK_HZ / MS_PER_S;
  localparam int unsigned HOLD_UNIT_MS   = 10;

  // Sizes
  localparam int unsigned NUM_STAGES  = 8;
  localparam int unsigned NUM_SENSORS = 10;
  localparam int unsigned NUM_VO      = 6;
  localparam int unsigned NUM_TRIP    = 4;
  localparam int unsigned NUM_OUT     = 5;
  localparam int unsigned CUR_SRC     = 9;
  localparam int unsigned LIGHT_SRC   = 17;
  localparam int unsigned EVT_SRC     = 20;

  // Current levels in hundredths of nominal
  localparam logic [9:0] PH_LVL_MIN  = 10'd50;
  localparam logic [9:0] PH_LVL_MAX  = 10'd800;
  localparam logic [9:0] PH_LVL_RST  = 10'd100;
  localparam logic [9:0] RES_LVL_MIN = 10'd10;
  localparam logic [9:0] RES_LVL_MAX = 10'd500;
  localparam logic [9:0] RES_LVL_RST = 10'd100;

  // Stage timing
  localparam logic [7:0] DELAY_RST = 8'd0;
  localparam logic [7:0] HOLD_MIN  = 8'd2;
  localparam logic [7:0] HOLD_RST  = 8'd2;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_PH_LVL    = 8'h08;
  localparam logic [7:0] OFS_RES_LVL   = 8'h0c;
  localparam logic [7:0] OFS_STAGE_EN  = 8'h10;
  localparam logic [7:0] OFS_TIMING    = 8'h20;
  localparam logic [7:0] OFS_MATRIX    = 8'h40;
  localparam logic [7:0] OFS_OUT_TRIP  = 8'h60;
  localparam logic [7:0] OFS_OUT_ALARM = 8'h64;
  localparam logic [7:0] OFS_EVT_ON    = 8'h70;
  localparam logic [7:0] OFS_EVT_OFF   = 8'h74;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h78;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h7c;

  // Field positions
  localparam int unsigned CTRL_INSTALL_BIT = 0;
  localparam int unsigned CTRL_SF_LINK_BIT = 1;
  localparam int unsigned CTRL_RELEASE_BIT = 2;
  localparam int unsigned MTX_LIGHT_LSB    = 9;
  localparam int unsigned TIM_HOLD_LSB     = 8;
  localparam int unsigned ALARM_LATCH_LSB  = 8;
  localparam int unsigned STAT_READY_BIT   = 0;
  localparam int unsigned STAT_SF_BIT      = 1;
  localparam int unsigned STAT_FLAG_LSB    = 2;
  localparam int unsigned STAT_TRIP_LSB    = 8;
  localparam int unsigned STAT_OUT_LSB     = 16;

  // Reset values
  localparam logic        SF_LINK_RST  = 1'b1;
  localparam logic [7:0]  STAGE_EN_RST = 8'h00;
  localparam logic [19:0] EVT_EN_RST   = 20'hfffff;

  typedef struct packed {
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] phase_c;
    logic [15:0] residual;
  } current_sample_t;

  typedef struct packed {
    logic [7:0] hold;
    logic [7:0] delay;
  } stage_timing_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DELAY = 3'b010,
    ST_TRIP  = 3'b100
  } stage_state_t;

  typedef enum logic [1:0] {
    INST_READY = 2'b01,
    INST_BUSY  = 2'b10
  } install_state_t;

endpackage : arc_pkg

// ### pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a change only once two stages agree
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level_q[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync

// ### arc_stage_timer.sv
`timescale 1ns/1ps
module arc_stage_timer
  import arc_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 enable,
  input  wire logic                 active,
  input  wire logic                 ms_tick,
  input  wire arc_pkg::stage_timing_t timing,
  output logic                      trip_q
);
  stage_state_t state_q;
  logic [11:0]  ms_cnt_q;
  logic [11:0]  hold_ms;

  assign hold_ms = 12'(timing.hold) * 12'(HOLD_UNIT_MS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= ST_IDLE;
      ms_cnt_q <= '0;
      trip_q   <= 1'b0;
    end else if (!enable) begin
      state_q  <= ST_IDLE; // [RULE3]
      ms_cnt_q <= '0;
      trip_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          ms_cnt_q <= '0;
          if (active && timing.delay == 8'd0) begin
            state_q <= ST_TRIP;
            trip_q  <= 1'b1;
          end else if (active) begin
            state_q <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          // Dropout restarts the delay
          if (!active) begin
            state_q  <= ST_IDLE;
            ms_cnt_q <= '0;
          end else if (ms_cnt_q >= 12'(timing.delay)) begin
            state_q  <= ST_TRIP; // [RULE4]
            trip_q   <= 1'b1;
            ms_cnt_q <= '0;
          end else if (ms_tick) begin
            ms_cnt_q <= ms_cnt_q + 12'd1;
          end
        end
        ST_TRIP: begin
          // Strict compare so hold never falls short
          if (ms_cnt_q > hold_ms && !active) begin
            state_q <= ST_IDLE; // [RULE5]
            trip_q  <= 1'b0;
            ms_cnt_q <= '0;
          end else if (ms_tick && ms_cnt_q <= hold_ms) begin
            ms_cnt_q <= ms_cnt_q + 12'd1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          trip_q  <= 1'b0;
        end
      endcase
    end
  end
endmodule : arc_stage_timer

// ### arc_stage_matrix_logic.sv
`timescale 1ns/1ps
// What this block does
// [RULE1] Phase flag when any phase exceeds level
// [RULE2] Residual flag when residual exceeds level
// [RULE3] Disabled stage never trips
// [RULE4] Enabled stage trips after programmable delay
// [RULE5] Trip holds for minimum hold time
// [RULE6] Self fault reaches relay when linked
// [RULE7] Install: busy until sensors link, then ready
// [RULE8] Current matrix links sources to stages
// [RULE9] Light matrix links sources to stages
// [RULE10] Both matrices selected: AND of results
// [RULE11] One matrix selected: that matrix alone
// [RULE12] Output matrix drives contacts, per-output latch
// [RULE13] Output links mirrored to route view
// [RULE14] Events logged only when enables set
// [RULE15] Configure latch on breaker trip outputs
// [RULE16] Delayed stage as breaker failure backup
// [RULE17] Latched output holds until release command
// [RULE18] Selections within one matrix are ORed
// [RULE19] Stage with no selections never activates
module arc_stage_matrix_logic
  import arc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = arc_pkg::MS_CYCLES_DFLT
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire arc_pkg::current_sample_t  current_sample,
  input  wire logic [NUM_SENSORS-1:0]    light_sensor_pins,
  input  wire logic                      sensor_link_ok_pin,
  input  wire logic                      arc_selfdiag_fault_pin,
  input  wire logic                      network_input_signal,
  input  wire logic [NUM_VO-1:0]         virtual_outputs,
  output logic [NUM_TRIP-1:0]            trip_contact_outputs,
  output logic                           alarm_contact_output,
  output logic                           self_fault_relay,
  output logic                           sensor_enum_req,
  output logic [NUM_STAGES*NUM_OUT-1:0]  general_route,
  output logic [EVT_SRC-1:0]             event_on,
  output logic [EVT_SRC-1:0]             event_off,
  output logic                           irq
);

  // Register state
  logic                          sf_link_q;
  logic [9:0]                    ph_lvl_q;
  logic [9:0]                    res_lvl_q;
  logic [NUM_STAGES-1:0]         stage_en_q;
  stage_timing_t                 timing_q [NUM_STAGES];
  logic [CUR_SRC+LIGHT_SRC-1:0]  matrix_q [NUM_STAGES];
  logic [31:0]                   out_trip_q;
  logic [NUM_STAGES-1:0]         out_alarm_q;
  logic [NUM_OUT-1:0]            out_latch_q;
  logic [EVT_SRC-1:0]            evt_on_en_q;
  logic [EVT_SRC-1:0]            evt_off_en_q;
  logic [EVT_SRC-1:0]            irq_stat_q;
  logic [EVT_SRC-1:0]            irq_mask_q;
  install_state_t                inst_q;

  // Datapath state
  logic                          ph_flag_q;
  logic                          res_flag_q;
  logic [NUM_SENSORS-1:0]        light_s;
  logic                          link_ok_s;
  logic                          selfdiag_s;
  logic [NUM_STAGES-1:0]         stage_trip;
  logic [NUM_STAGES-1:0]         stage_act;
  logic [NUM_OUT-1:0]            out_drive;
  logic [NUM_OUT-1:0]            latched_q;
  logic [NUM_STAGES*NUM_OUT-1:0] out_sel;
  logic [EVT_SRC-1:0]            evt_now;
  logic [EVT_SRC-1:0]            evt_prev_q;
  logic [EVT_SRC-1:0]            evt_on_d;
  logic [EVT_SRC-1:0]            evt_off_d;
  logic [15:0]                   ms_div_q;
  logic                          ms_tick_q;

  // APB decode
  logic                          wr_acc;
  logic                          rd_acc;
  logic                          setup;
  logic [31:0]                   rdata_d;
  logic                          err_d;
  logic                          release_cmd;
  logic                          install_cmd;

  function automatic logic in_array(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'(4 * NUM_STAGES)) && (a[1:0] == 2'b00);
  endfunction : in_array

  function automatic logic [9:0] clamp_lvl(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_lvl

  assign setup       = psel && !penable;
  assign wr_acc      = psel && penable && pwrite;
  assign rd_acc      = psel && penable && !pwrite;
  assign release_cmd = wr_acc && paddr == OFS_CTRL && pwdata[CTRL_RELEASE_BIT];
  assign install_cmd = wr_acc && paddr == OFS_CTRL && pwdata[CTRL_INSTALL_BIT];
  assign out_sel     = {out_alarm_q, out_trip_q};

  pin_sync #(.WIDTH(NUM_SENSORS + 2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({sensor_link_ok_pin, arc_selfdiag_fault_pin, light_sensor_pins}),
    .level_q ({link_ok_s, selfdiag_s, light_s})
  );

  // Shared 1 ms tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_q  <= '0;
      ms_tick_q <= 1'b0;
    end else if (ms_div_q == 16'(MS_CYCLES - 1)) begin
      ms_div_q  <= '0;
      ms_tick_q <= 1'b1;
    end else begin
      ms_div_q  <= ms_div_q + 16'd1;
      ms_tick_q <= 1'b0;
    end
  end

  // Writes land in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sf_link_q    <= SF_LINK_RST;
      ph_lvl_q     <= PH_LVL_RST;
      res_lvl_q    <= RES_LVL_RST;
      stage_en_q   <= STAGE_EN_RST;
      out_trip_q   <= '0;
      out_alarm_q  <= '0;
      out_latch_q  <= '0;
      evt_on_en_q  <= EVT_EN_RST;
      evt_off_en_q <= EVT_EN_RST;
      irq_mask_q   <= '0;
      for (int i = 0; i < NUM_STAGES; i++) begin
        timing_q[i] <= '{hold: HOLD_RST, delay: DELAY_RST};
        matrix_q[i] <= '0;
      end
    end else if (wr_acc) begin
      if (paddr == OFS_CTRL) begin
        sf_link_q <= pwdata[CTRL_SF_LINK_BIT];
      end else if (paddr == OFS_PH_LVL) begin
        ph_lvl_q <= clamp_lvl(pwdata[9:0], PH_LVL_MIN, PH_LVL_MAX);
      end else if (paddr == OFS_RES_LVL) begin
        res_lvl_q <= clamp_lvl(pwdata[9:0], RES_LVL_MIN, RES_LVL_MAX);
      end else if (paddr == OFS_STAGE_EN) begin
        stage_en_q <= pwdata[NUM_STAGES-1:0];
      end else if (in_array(paddr, OFS_TIMING)) begin
        timing_q[paddr[4:2]].delay <= pwdata[7:0];
        timing_q[paddr[4:2]].hold  <= (pwdata[15:8] < HOLD_MIN) ? HOLD_MIN : pwdata[15:8];
      end else if (in_array(paddr, OFS_MATRIX)) begin
        matrix_q[paddr[4:2]] <= pwdata[CUR_SRC+LIGHT_SRC-1:0];
      end else if (paddr == OFS_OUT_TRIP) begin
        out_trip_q <= pwdata;
      end else if (paddr == OFS_OUT_ALARM) begin
        out_alarm_q <= pwdata[NUM_STAGES-1:0];
        out_latch_q <= pwdata[ALARM_LATCH_LSB +: NUM_OUT];
      end else if (paddr == OFS_EVT_ON) begin
        evt_on_en_q <= pwdata[EVT_SRC-1:0];
      end else if (paddr == OFS_EVT_OFF) begin
        evt_off_en_q <= pwdata[EVT_SRC-1:0];
      end else if (paddr == OFS_IRQ_MASK) begin
        irq_mask_q <= pwdata[EVT_SRC-1:0];
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_d = '0;
    err_d   = 1'b0;
    if (paddr == OFS_CTRL) begin
      rdata_d[CTRL_SF_LINK_BIT] = sf_link_q;
    end else if (paddr == OFS_STATUS) begin
      rdata_d[STAT_READY_BIT] = (inst_q == INST_READY);
      rdata_d[STAT_SF_BIT] = selfdiag_s;
      rdata_d[STAT_FLAG_LSB +: 2] = {res_flag_q, ph_flag_q};
      rdata_d[STAT_TRIP_LSB +: NUM_STAGES] = stage_trip;
      rdata_d[STAT_OUT_LSB +: NUM_OUT] = {alarm_contact_output, trip_contact_outputs};
    end else if (paddr == OFS_PH_LVL) begin
      rdata_d[9:0] = ph_lvl_q;
    end else if (paddr == OFS_RES_LVL) begin
      rdata_d[9:0] = res_lvl_q;
    end else if (paddr == OFS_STAGE_EN) begin
      rdata_d[NUM_STAGES-1:0] = stage_en_q;
    end else if (in_array(paddr, OFS_TIMING)) begin
      rdata_d[15:0] = timing_q[paddr[4:2]];
    end else if (in_array(paddr, OFS_MATRIX)) begin
      rdata_d[CUR_SRC+LIGHT_SRC-1:0] = matrix_q[paddr[4:2]];
    end else if (paddr == OFS_OUT_TRIP) begin
      rdata_d = out_trip_q;
    end else if (paddr == OFS_OUT_ALARM) begin
      rdata_d[NUM_STAGES-1:0] = out_alarm_q;
      rdata_d[ALARM_LATCH_LSB +: NUM_OUT] = out_latch_q;
    end else if (paddr == OFS_EVT_ON) begin
      rdata_d[EVT_SRC-1:0] = evt_on_en_q;
    end else if (paddr == OFS_EVT_OFF) begin
      rdata_d[EVT_SRC-1:0] = evt_off_en_q;
    end else if (paddr == OFS_IRQ_STAT) begin
      rdata_d[EVT_SRC-1:0] = irq_stat_q;
    end else if (paddr == OFS_IRQ_MASK) begin
      rdata_d[EVT_SRC-1:0] = irq_mask_q;
    end else begin
      err_d = 1'b1;
    end
  end

  // Zero wait: answer registered from setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      prdata  <= (setup && !pwrite) ? rdata_d : '0;
      pslverr <= setup && err_d;
      pready  <= setup;
    end
  end

  // Overcurrent flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_flag_q  <= 1'b0;
      res_flag_q <= 1'b0;
    end else begin
      ph_flag_q  <= (current_sample.phase_a > 16'(ph_lvl_q)) ||
                    (current_sample.phase_b > 16'(ph_lvl_q)) ||
                    (current_sample.phase_c > 16'(ph_lvl_q)); // [RULE1]
      res_flag_q <= current_sample.residual > 16'(res_lvl_q); // [RULE2]
    end
  end

  // Matrix correlation and stage timers
  generate
    for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
      logic [CUR_SRC-1:0]   cur_sel;
      logic [LIGHT_SRC-1:0] light_sel;
      logic                 cur_hit;
      logic                 light_hit;
      assign cur_sel   = matrix_q[s][CUR_SRC-1:0];
      assign light_sel = matrix_q[s][MTX_LIGHT_LSB +: LIGHT_SRC];
      assign cur_hit   = |(cur_sel & {virtual_outputs, network_input_signal, res_flag_q, ph_flag_q}); // [RULE8] [RULE18]
      assign light_hit = |(light_sel & {virtual_outputs, network_input_signal, light_s}); // [RULE9] [RULE18]
      // Empty columns never fire
      assign stage_act[s] = (|cur_sel || |light_sel) && // [RULE19]
                            (!(|cur_sel) || cur_hit) && // [RULE10] [RULE11]
                            (!(|light_sel) || light_hit); // [RULE10] [RULE11]

      arc_stage_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (stage_en_q[s]),
        .active  (stage_act[s]),
        .ms_tick (ms_tick_q),
        .timing  (timing_q[s]),
        .trip_q  (stage_trip[s])
      );
    end

    for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
      logic [NUM_STAGES-1:0] sel;
      assign sel          = out_sel[o*NUM_STAGES +: NUM_STAGES];
      assign out_drive[o] = |(sel & stage_trip); // [RULE12]

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          latched_q[o] <= 1'b0;
        end else if (out_latch_q[o] && out_drive[o]) begin
          latched_q[o] <= 1'b1; // [RULE17]
        end else if (release_cmd || !out_latch_q[o]) begin
          latched_q[o] <= 1'b0; // [RULE17]
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_contact_outputs <= '0;
      alarm_contact_output <= 1'b0;
      general_route        <= '0;
      self_fault_relay     <= 1'b0;
    end else begin
      trip_contact_outputs <= out_drive[NUM_TRIP-1:0] | latched_q[NUM_TRIP-1:0]; // [RULE12]
      alarm_contact_output <= out_drive[NUM_TRIP] | latched_q[NUM_TRIP]; // [RULE12]
      general_route        <= out_sel; // [RULE13]
      self_fault_relay     <= selfdiag_s && sf_link_q; // [RULE6]
    end
  end

  // Sensor installation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inst_q          <= INST_READY;
      sensor_enum_req <= 1'b0;
    end else begin
      case (inst_q)
        INST_READY: begin
          if (install_cmd) begin
            inst_q          <= INST_BUSY; // [RULE7]
            sensor_enum_req <= 1'b1;
          end
        end
        INST_BUSY: begin
          if (link_ok_s) begin
            inst_q          <= INST_READY; // [RULE7]
            sensor_enum_req <= 1'b0;
          end
        end
        default: begin
          inst_q          <= INST_READY;
          sensor_enum_req <= 1'b0;
        end
      endcase
    end
  end

  // Events and interrupt
  assign evt_now   = {stage_trip, light_s, res_flag_q, ph_flag_q};
  assign evt_on_d  = evt_now & ~evt_prev_q & evt_on_en_q; // [RULE14]
  assign evt_off_d = ~evt_now & evt_prev_q & evt_off_en_q; // [RULE14]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_prev_q <= '0;
      event_on   <= '0;
      event_off  <= '0;
    end else begin
      evt_prev_q <= evt_now;
      event_on   <= evt_on_d;
      event_off  <= evt_off_d;
    end
  end

  // Set wins over clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (rd_acc && paddr == OFS_IRQ_STAT) begin
      irq_stat_q <= evt_on_d | evt_off_d;
    end else begin
      irq_stat_q <= irq_stat_q | evt_on_d | evt_off_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule : arc_stage_matrix_logic

// ### arc_field_model.sv
`timescale 1ns/1ps
module arc_field_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enum_req,
  input  wire logic [7:0] link_delay,
  output logic            link_ok
);
  logic [7:0] cnt_q;
  // Link up link_delay cycles into a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= enum_req ? cnt_q + {7'h0, cnt_q != 8'hff} : 8'h00;
    end
  end
  assign link_ok = enum_req && cnt_q >= link_delay;
endmodule : arc_field_model

// ### arc_stage_matrix_logic_monitor.sv
`timescale 1ns/1ps
module arc_matrix_monitor
  import arc_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 sensor_link_ok_pin,
  input wire logic                 arc_selfdiag_fault_pin,
  input wire logic [NUM_TRIP-1:0]  trip_contact_outputs,
  input wire logic                 self_fault_relay,
  input wire logic                 sensor_enum_req,
  input wire logic [39:0]          general_route,
  input wire logic [EVT_SRC-1:0]   event_on
);
  logic        wr, wr_inst, wr_route;
  logic [31:0] wd_q;
  assign wr = psel && penable && pwrite;
  assign wr_inst = wr && paddr == OFS_CTRL && pwdata[CTRL_INSTALL_BIT];
  assign wr_route = wr && paddr == OFS_OUT_TRIP;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_q <= '0;
    end else if (wr_route) begin
      wd_q <= pwdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  inst_start_a: assert property ($rose(sensor_enum_req) |-> $past(wr_inst))
    else $error("install unasked");
  inst_end_a: assert property ($fell(sensor_enum_req) |-> $past(sensor_link_ok_pin, 2))
    else $error("ready without link");
  sf_rise_a: assert property ($rose(self_fault_relay) |-> $past(arc_selfdiag_fault_pin, 3))
    else $error("relay without fault");
  sf_quiet_a: assert property (!arc_selfdiag_fault_pin [*6] |-> !self_fault_relay)
    else $error("relay stuck");
  sf_unlink_a: assert property (wr && paddr == OFS_CTRL && !pwdata[1] |-> ##2 !self_fault_relay)
    else $error("relay while unlinked");
  trip_route_a: assert property ($rose(trip_contact_outputs[0]) |-> general_route[7:0] != 8'h00)
    else $error("trip without route");
  route_mirror_a: assert property (wr_route |=> ##[0:1] general_route[31:0] == wd_q)
    else $error("route view differs");
  evt_pulse_a: assert property (event_on[12] |=> !event_on[12])
    else $error("event not a pulse");
  cover property ($fell(sensor_enum_req));
  cover property ($rose(trip_contact_outputs[0]));
  cover property (event_on[12]);
endmodule : arc_matrix_monitor
bind arc_stage_matrix_logic arc_matrix_monitor i_mon (.*);

// ### arc_stage_matrix_logic_tb.sv
`timescale 1ns/1ps
module arc_stage_matrix_logic_tb;
  import arc_pkg::*;
  typedef struct packed {logic e; logic [31:0] d; logic [31:0] m;} note_t;
  logic            pclk = 1'b0;
  logic            presetn, psel, penable, pwrite, pready, pslverr, sensor_link_ok_pin;
  logic            arc_selfdiag_fault_pin, network_input_signal, alarm_contact_output;
  logic            self_fault_relay, sensor_enum_req, irq;
  logic [7:0]      paddr, ld;
  logic [31:0]     pwdata, prdata;
  current_sample_t current_sample;
  logic [9:0]      light_sensor_pins;
  logic [5:0]      virtual_outputs;
  logic [3:0]      trip_contact_outputs;
  logic [39:0]     general_route;
  logic [19:0]     event_on, event_off;
  logic [15:0]     seed = 16'h5bf4;
  int              n_mismatch = 0;
  int              cmp_count = 0;
  int              k;
  note_t           exp_q[$];
  note_t           note;
  always #20 pclk = ~pclk;
  arc_stage_matrix_logic #(.MS_CYCLES(10)) i_dut (.*);
  arc_field_model i_field (.pclk, .presetn, .enum_req(sensor_enum_req), .link_delay(ld),
    .link_ok(sensor_link_ok_pin));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic err);
    exp_q.push_back('{err, e, m});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask : wt
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      note = exp_q.size() > 0 ? exp_q.pop_front() : '{1'b1, 32'h0, 32'h0};
      cmp({pslverr, prdata & note.m}, {note.e, note.d & note.m});
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, network_input_signal, arc_selfdiag_fault_pin} = '0;
    {paddr, pwdata, virtual_outputs, light_sensor_pins, current_sample} = '0;
    ld = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    seed = lfsr(seed);
    current_sample <= '{{10'h0, seed[5:0]}, 16'd100, {10'h0, seed[11:6]}, {10'h0, seed[15:10]}};
    light_sensor_pins[9:4] <= seed[9:4];
    rd(OFS_CTRL, 32'h2, 32'h2, 0);
    rd(OFS_PH_LVL, 32'd100, 32'h3ff, 0);
    rd(OFS_RES_LVL, 32'd100, 32'h3ff, 0);
    rd(OFS_TIMING, 32'h200, 32'hffff, 0);
    rd(OFS_EVT_OFF, 32'hfffff, 32'hfffff, 0);
    rd(OFS_STATUS, 32'h1, 32'hd, 0);
    rd(8'h18, 32'h0, 32'hffffffff, 1);
    wr(OFS_PH_LVL, 32'd10);
    rd(OFS_PH_LVL, 32'd50, 32'h3ff, 0);
    wr(OFS_PH_LVL, 32'd100);
    wr(OFS_TIMING, 32'h0);
    rd(OFS_TIMING, 32'h200, 32'hffff, 0);
    current_sample.phase_b <= 16'd101;
    current_sample.residual <= 16'd101;
    rd(OFS_STATUS, 32'hc, 32'hc, 0);
    {current_sample.phase_b, current_sample.residual} <= '0;
    wr(OFS_MATRIX, 32'h200);
    wr(OFS_OUT_TRIP, 32'h1);
    wr(OFS_OUT_ALARM, 32'h101);
    light_sensor_pins[0] <= 1'b1;
    wt(10);
    rd(OFS_STATUS, 32'h0, 32'hff00, 0);
    wr(OFS_STAGE_EN, 32'h1);
    wt(10);
    rd(OFS_STATUS, 32'h110100, 32'h1fff00, 0);
    light_sensor_pins[0] <= 1'b0;
    wt(10);
    rd(OFS_STATUS, 32'h110100, 32'h1fff00, 0);
    wt(250);
    rd(OFS_STATUS, 32'h10000, 32'h1fff00, 0);
    wr(OFS_CTRL, 32'h6);
    wt(3);
    rd(OFS_STATUS, 32'h0, 32'h1fff00, 0);
    wr(OFS_MATRIX + 8'h4, 32'h401);
    wr(OFS_MATRIX + 8'h8, 32'h80800);
    wr(OFS_MATRIX + 8'hc, 32'h8);
    wr(OFS_TIMING + 8'hc, 32'h203);
    wr(OFS_STAGE_EN, 32'h1f);
    light_sensor_pins[1] <= 1'b1;
    wt(10);
    rd(OFS_STATUS, 32'h0, 32'h1e00, 0);
    current_sample.phase_a <= 16'd101;
    wt(10);
    rd(OFS_STATUS, 32'h200, 32'h1e00, 0);
    network_input_signal <= 1'b1;
    wt(10);
    rd(OFS_STATUS, 32'h600, 32'h1e00, 0);
    virtual_outputs[0] <= 1'b1;
    wt(8);
    rd(OFS_STATUS, 32'h600, 32'h1e00, 0);
    wt(25);
    rd(OFS_STATUS, 32'he00, 32'h1e00, 0);
    {light_sensor_pins[1], network_input_signal, virtual_outputs[0], current_sample.phase_a} <= '0;
    for (k = 0; k < 2; k++) begin
      wt(260);
      rd(OFS_IRQ_STAT, 32'h0, 32'h0, 0);
      wr(OFS_IRQ_MASK, 32'h8000);
      virtual_outputs[0] <= 1'b1;
      wt(40);
      cmp({32'h0, irq}, {32'h0, k == 0});
      rd(OFS_IRQ_STAT, {16'h0, k == 0, 15'h0}, 32'h8000, 0);
      virtual_outputs[0] <= 1'b0;
      wr(OFS_EVT_ON, 32'hf7fff);
    end
    arc_selfdiag_fault_pin <= 1'b1;
    wt(8);
    cmp({32'h0, self_fault_relay}, 33'h1);
    wr(OFS_CTRL, 32'h0);
    wt(3);
    cmp({32'h0, self_fault_relay}, 33'h0);
    rd(OFS_STATUS, 32'h2, 32'h2, 0);
    arc_selfdiag_fault_pin <= 1'b0;
    wt(5);
    for (int i = 0; i < 2; i++) begin
      ld <= i ? 8'd60 : 8'd0;
      wr(OFS_CTRL, 32'h3);
      rd(OFS_STATUS, 32'h0, 32'h1, 0);
      for (k = 0; k < 300 && sensor_enum_req; k++) @(posedge pclk);
      if (k == 300) n_mismatch++;
      rd(OFS_STATUS, 32'h1, 32'h1, 0);
    end
    results();
  end
endmodule : arc_stage_matrix_logic_tb
